// >>> src/float_mode_background_monitor.sv
// top: background light monitor with ahb-lite register slave and interrupt
`timescale 1ns/1ps

// Operation
// - slot a flags sit in status bits 3..0, channel 1 at bit 0.
// - slot b flags sit in status bits 7..4, channel 1 at bit 4.
// - reading the status word returns the flags then clears them; bits 15..8 read zero.
// - a channel flag sets once its threshold was exceeded the configured number of times.
// - only float-mode subtract results strictly above the slot limit count as exceedances.
// - occurrence setting 0 never sets, 1 after one, 2 after four, 3 after sixteen.
// - each slot limit is a 14-bit read/write field in bits 13..0 resetting to 0x3000.
// - slot b has its own occurrence setting and limit with the same encoding.
// - occurrence settings reset to 0 so flags stay clear until software selects one.
module float_mode_background_monitor
  import bg_monitor_pkg::*;
(
  // clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic [31:0]                      hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  // adc sequencer
  input  wire bg_monitor_pkg::adc_result_s adc_result,
  // interrupt
  output logic                             irq
);
  import bg_monitor_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0]      cfg_a_ff;
  logic [15:0]      cfg_b_ff;
  logic [3:0]       slot_a_ambient_flags_ff;
  logic [3:0]       slot_b_ambient_flags_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [31:0]      hrdata_ff;
  logic             irq_ff;
  logic             hreadyout_ff;
  logic             hresp_ff;

  // address phase capture
  logic             wr_pend_ff;
  logic [7:0]       wr_idx_ff;
  logic             rd_status_ff;
  logic             rd_take;

  logic             access;
  logic [7:0]       idx;
  logic             word_ok;
  logic [31:0]      nxt_hrdata;
  logic [3:0]       set_a;
  logic [3:0]       set_b;
  slot_cfg_s        slot_a_cfg;
  slot_cfg_s        slot_b_cfg;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign access  = hsel && hready && htrans[1];
  assign idx     = haddr[9:2];
  assign word_ok = haddr[1:0] == 2'h0 && haddr[31:10] == 22'h0;

  // read data mux, registered for the data phase
  always_comb
  begin
    nxt_hrdata = 32'h0000_0000;
    if (!word_ok)
      nxt_hrdata = 32'h0000_0000;
    else if (idx == STATUS_IDX)
      nxt_hrdata = {16'h0000, 8'h00,
                    slot_b_ambient_flags_ff, slot_a_ambient_flags_ff};
    else if (idx == CFG_A_IDX)
      nxt_hrdata = {16'h0000, cfg_a_ff};
    else if (idx == CFG_B_IDX)
      nxt_hrdata = {16'h0000, cfg_b_ff};
    else if (idx == IRQ_STAT_IDX)
      nxt_hrdata = {30'h0, irq_stat_ff};
    else if (idx == IRQ_MASK_IDX)
      nxt_hrdata = {30'h0, irq_mask_ff};
  end

  // read data register; unmapped words read zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= 32'h0000_0000;
    else if (access && !hwrite)
      hrdata_ff <= nxt_hrdata;
  end

  // capture write address for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= access && hwrite && word_ok;
      wr_idx_ff  <= idx;
    end
  end

  // a status read is taken in its address phase: read data captures the flags
  // at that edge and the same edge clears them, so a flag raised meanwhile survives
  assign rd_take = access && !hwrite && word_ok && idx == STATUS_IDX;

  // marks the data phase of a status read for the checks below
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_status_ff <= 1'b0;
    else
      rd_status_ff <= rd_take;
  end

  // zero wait states and an always okay response, held in flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
    else
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // slot a and slot b settings, writable word by word
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_a_ff <= CFG_RESET;
      cfg_b_ff <= CFG_RESET;
    end
    else if (wr_pend_ff)
    begin
      if (wr_idx_ff == CFG_A_IDX)
        cfg_a_ff <= hwdata[15:0];
      else if (wr_idx_ff == CFG_B_IDX)
        cfg_b_ff <= hwdata[15:0];
    end
  end

  assign slot_a_cfg.hit_count_select = cfg_a_ff[SEL_MSB:SEL_LSB];
  assign slot_a_cfg.ambient_limit    = cfg_a_ff[LIMIT_MSB:LIMIT_LSB];
  assign slot_b_cfg.hit_count_select = cfg_b_ff[SEL_MSB:SEL_LSB];
  assign slot_b_cfg.ambient_limit    = cfg_b_ff[LIMIT_MSB:LIMIT_LSB];

  // ----------------------------------------------------------------
  // slot monitors
  // ----------------------------------------------------------------
  slot_monitor u_slot_a (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .res         (adc_result),
    .this_slot_b (1'b0),
    .cfg         (slot_a_cfg),
    .clear       (rd_take),
    .set_flags   (set_a)
  );

  slot_monitor u_slot_b (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .res         (adc_result),
    .this_slot_b (1'b1),
    .cfg         (slot_b_cfg),
    .clear       (rd_take),
    .set_flags   (set_b)
  );

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // sticky flags, cleared as a status read captures them; a set in that cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slot_a_ambient_flags_ff <= STAT_RESET[3:0];
      slot_b_ambient_flags_ff <= STAT_RESET[7:4];
    end
    else
    begin
      slot_a_ambient_flags_ff <= (rd_take ? 4'h0 : slot_a_ambient_flags_ff)
                                 | set_a;
      slot_b_ambient_flags_ff <= (rd_take ? 4'h0 : slot_b_ambient_flags_ff)
                                 | set_b;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  // sticky event bits, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_ff <= '0;
    else
    begin
      if (wr_pend_ff && wr_idx_ff == IRQ_STAT_IDX)
        irq_stat_ff <= (irq_stat_ff & ~hwdata[IRQ_W-1:0]) | {|set_b, |set_a};
      else
        irq_stat_ff <= irq_stat_ff | {|set_b, |set_a};
    end
  end

  // interrupt mask, one enables
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_mask_ff <= '0;
    else if (wr_pend_ff && wr_idx_ff == IRQ_MASK_IDX)
      irq_mask_ff <= hwdata[IRQ_W-1:0];
  end

  // registered level output
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
  end

  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  upper_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_status_ff |-> hrdata_ff[31:8] == 24'h0)
    else $error("status upper bits not zero");

  read_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && set_a == 4'h0 && set_b == 4'h0)
      |=> slot_a_ambient_flags_ff == 4'h0 && slot_b_ambient_flags_ff == 4'h0)
    else $error("status read did not clear flags");

  read_returns_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_status_ff |-> hrdata_ff[3:0] == $past(slot_a_ambient_flags_ff))
    else $error("slot a flags not returned");

  read_returns_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_status_ff |-> hrdata_ff[7:4] == $past(slot_b_ambient_flags_ff))
    else $error("slot b flags not returned");

  never_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    slot_a_cfg.hit_count_select == 2'h0 |-> set_a == 4'h0)
    else $error("slot a flag set with setting zero");

  never_set_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
    slot_b_cfg.hit_count_select == 2'h0 |-> set_b == 4'h0)
    else $error("slot b flag set with setting zero");

  subtract_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(adc_result.valid && adc_result.subtract) |-> (set_a | set_b) == 4'h0)
    else $error("flag set outside subtract cycle");

  set_sticks_a: assert property (@(posedge hclk) disable iff (!hresetn)
    set_a[0] |=> slot_a_ambient_flags_ff[0])
    else $error("slot a channel 1 flag missed");

  first_hit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (slot_a_cfg.hit_count_select == 2'h1 && adc_result.valid && adc_result.subtract
     && !adc_result.slot_b && adc_result.channel == 2'h0 && !rd_status_ff
     && $stable(slot_a_cfg.hit_count_select)
     && adc_result.value > slot_a_cfg.ambient_limit) |-> set_a[0])
    else $error("single exceedance did not set flag");

  reset_cfg_a: assert property (@(posedge hclk)
    $rose(hresetn) |-> cfg_a_ff == CFG_RESET && cfg_b_ff == CFG_RESET)
    else $error("config not at reset value");

  write_lands_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_ff && wr_idx_ff == CFG_A_IDX) |=> cfg_a_ff == $past(hwdata[15:0]))
    else $error("slot a config write lost");

  write_lands_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_ff && wr_idx_ff == CFG_B_IDX) |=> cfg_b_ff == $past(hwdata[15:0]))
    else $error("slot b config write lost");

  flags_stick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    set_a != 4'h0 |=> (slot_a_ambient_flags_ff & $past(set_a)) == $past(set_a))
    else $error("slot a flag set request lost");

  flags_stick_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
    set_b != 4'h0 |=> (slot_b_ambient_flags_ff & $past(set_b)) == $past(set_b))
    else $error("slot b flag set request lost");

  flags_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!rd_take && set_a == 4'h0) |=> $stable(slot_a_ambient_flags_ff))
    else $error("slot a flags changed without set or read");

  flags_hold_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!rd_take && set_b == 4'h0) |=> $stable(slot_b_ambient_flags_ff))
    else $error("slot b flags changed without set or read");

  below_limit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (adc_result.valid && !adc_result.slot_b
     && adc_result.value <= slot_a_cfg.ambient_limit) |-> set_a == 4'h0)
    else $error("slot a counted a result at or below its limit");

  below_limit_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (adc_result.valid && adc_result.slot_b
     && adc_result.value <= slot_b_cfg.ambient_limit) |-> set_b == 4'h0)
    else $error("slot b counted a result at or below its limit");

  one_channel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (set_a & ~(4'h1 << adc_result.channel)) == 4'h0)
    else $error("slot a flag set for another channel");

  one_channel_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (set_b & ~(4'h1 << adc_result.channel)) == 4'h0)
    else $error("slot b flag set for another channel");

  first_hit_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (slot_b_cfg.hit_count_select == 2'h1 && adc_result.valid && adc_result.subtract
     && adc_result.slot_b && adc_result.channel == 2'h0
     && adc_result.value > slot_b_cfg.ambient_limit) |-> set_b[0])
    else $error("slot b single exceedance did not set flag");

endmodule // float_mode_background_monitor

// >>> common/bg_monitor_pkg.sv
// package: register map, field layout, reset values and carriers of the background monitor
package bg_monitor_pkg;

  // register indices as printed (0x16 is not a multiple of four, so byte address = 4 * index)
  localparam logic [7:0] STATUS_IDX   = 8'h04;
  localparam logic [7:0] CFG_A_IDX    = 8'h16;
  localparam logic [7:0] CFG_B_IDX    = 8'h1c;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h30;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h31;

  // field positions
  localparam int SEL_MSB   = 15;
  localparam int SEL_LSB   = 14;
  localparam int LIMIT_MSB = 13;
  localparam int LIMIT_LSB = 0;

  // reset values
  localparam logic [15:0] CFG_RESET  = 16'h3000;
  localparam logic [15:0] STAT_RESET = 16'h0000;

  // hit count targets per occurrence setting
  localparam logic [4:0] HITS_ONE     = 5'h01;
  localparam logic [4:0] HITS_FOUR    = 5'h04;
  localparam logic [4:0] HITS_SIXTEEN = 5'h10;

  // interrupt events: bit 0 slot a flag raised, bit 1 slot b flag raised
  localparam int IRQ_W = 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // one adc result from the sequencer
  typedef struct packed {
    logic        valid;     // result strobe
    logic        subtract;  // float-mode subtract cycle
    logic        slot_b;    // 0 = slot a, 1 = slot b
    logic [1:0]  channel;   // 0..3 = channel 1..4
    logic [13:0] value;
  } adc_result_s;

  // one slot's configuration
  typedef struct packed {
    logic [1:0]  hit_count_select;
    logic [13:0] ambient_limit;
  } slot_cfg_s;

endpackage

// >>> src/hit_counter.sv
// one channel exceedance counter with saturation and flag condition
`timescale 1ns/1ps
module hit_counter
  import bg_monitor_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       hit,
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  // result
  output logic            reached
);

  logic [4:0] count_ff;
  logic [4:0] target;

  // target count for the selected occurrence setting
  always_comb
  begin
    case (sel)
      2'h1:    target = HITS_ONE;
      2'h2:    target = HITS_FOUR;
      2'h3:    target = HITS_SIXTEEN;
      default: target = 5'h1f;
    endcase
  end

  // counter saturates at the target, cleared on read or setting change
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_ff <= 5'h00;
    else if (clear)
      count_ff <= (hit && sel != 2'h0) ? 5'h01 : 5'h00;  // a hit in the clear cycle counts
    else if (hit && sel != 2'h0 && count_ff < target)
      count_ff <= count_ff + 5'h01;
  end

  // condition holds when this hit reaches the target; a hit in the clear cycle is the first
  assign reached = hit && sel != 2'h0 &&
                   ((clear ? 5'h01 : count_ff + 5'h01) >= target);

  // the count never runs past the largest target
  no_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    count_ff <= HITS_SIXTEEN)
    else $error("hit counter ran past its largest target");

endmodule // hit_counter

// >>> src/slot_monitor.sv
// one time slot: four channel comparators and counters
`timescale 1ns/1ps
module slot_monitor
  import bg_monitor_pkg::*;
(
  // clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // sequencer result and slot settings
  input  wire bg_monitor_pkg::adc_result_s res,
  input  wire logic                     this_slot_b,
  input  wire bg_monitor_pkg::slot_cfg_s cfg,
  input  wire logic                     clear,
  // per channel flag set requests
  output logic [3:0]                    set_flags
);

  logic [1:0] sel_q_ff;
  logic       sel_changed;

  // remember the setting so that a change clears the counters
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sel_q_ff <= 2'h0;
    else
      sel_q_ff <= cfg.hit_count_select;
  end

  assign sel_changed = sel_q_ff != cfg.hit_count_select;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_ch
      logic hit;
      // only subtract cycles of this slot, strictly greater than limit
      assign hit = res.valid && res.subtract && (res.slot_b == this_slot_b) &&
                   (res.channel == 2'(ch)) && (res.value > cfg.ambient_limit);
      hit_counter u_cnt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .hit     (hit),
        .clear   (clear || sel_changed),
        .sel     (cfg.hit_count_select),
        .reached (set_flags[ch])
      );
    end
  endgenerate

endmodule // slot_monitor

// >>> verif/test_float_mode_background_monitor.sv
// testbench: background monitor compared with a behavioural register and counter model
`timescale 1ns/1ps
module test_float_mode_background_monitor;
  import bg_monitor_pkg::*;

  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  adc_result_s adc_result;
  logic        irq;
  int          mismatches;
  int          comparisons;
  int          seed;
  int          cnt [8];
  int          sel [2];
  int          lim [2];
  int          targ [4] = '{100, 1, 4, 16};
  int          flags;
  int          irq_stat;
  int          irq_mask;

  assign hready = hreadyout;  // single slave drives the bus ready

  float_mode_background_monitor u_dut (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hwdata     (hwdata),
    .hready     (hready),
    .hrdata     (hrdata),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .adc_result (adc_result),
    .irq        (irq)
  );

  // clock at 25 ns period
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task final_report;
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // compare a read word
  task check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // compare the interrupt line mid-cycle, where it has settled
  task check_irq(input logic exp);
    @(negedge hclk);
    comparisons++;
    if (irq !== exp)
    begin
      mismatches++;
      $display("unexpected irq at %0t: got %h expected %h", $time, irq, exp);
    end
    @(posedge hclk);
  endtask

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  function automatic logic [31:0] a(input logic [7:0] idx);
    return {22'h0, idx, 2'h0};  // byte address is four times the index
  endfunction

  // bounded wait for hready high at a rising edge
  task wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        mismatches++;
        final_report();
      end
      @(posedge hclk);
    end
  endtask

  // one single transfer: address phase then data phase
  task bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr  <= addr;
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check_word({31'h0, hresp}, 32'h0);  // okay response on every transfer
  endtask

  task wr(input logic [31:0] addr, input logic [31:0] wd);
    logic [31:0] r;
    bus(1'b1, addr, wd, r);
  endtask

  task rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, addr, 32'h0, r);
    check_word(r, exp);
  endtask

  // status read returns the flags, then flags and counters clear
  task read_status;
    logic [31:0] exp;
    exp = 32'(flags);
    flags = 0;
    foreach (cnt[k]) cnt[k] = 0;
    rd_chk(a(STATUS_IDX), exp);
  endtask

  // slot configuration write; a changed setting clears that slot's counters
  task write_cfg(input int s, input int sv, input int lv);
    if (sv != sel[s])
      for (int k = 0; k < 4; k++) cnt[s * 4 + k] = 0;
    sel[s] = sv;
    lim[s] = lv;
    wr(s ? a(CFG_B_IDX) : a(CFG_A_IDX), {16'h0, 2'(sv), 14'(lv)});
  endtask

  // ----------------------------------------------------------------
  // sequencer driver and counter model
  // ----------------------------------------------------------------
  task adc(input int s, input int ch, input int sub, input int v);
    int k;
    adc_result <= {1'b1, 1'(sub), 1'(s), 2'(ch), 14'(v)};
    @(posedge hclk);
    k = s * 4 + ch;
    if (sub != 0 && v > lim[s] && sel[s] != 0)
    begin
      if (cnt[k] < targ[sel[s]]) cnt[k]++;  // saturate at target
      if (cnt[k] == targ[sel[s]])
      begin
        flags    |= 1 << k;
        irq_stat |= 1 << s;
      end
    end
  endtask

  task adc_idle;
    adc_result <= '0;
  endtask

  function automatic int hitv(input int s);
    return lim[s] + 1 + (($random(seed) & 32'h0fff) % (16383 - lim[s]));
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int lv;
    int ch;
    int m;
    seed = 8;
    mismatches = 0;
    comparisons = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    adc_result = '0;
    flags = 0;
    irq_stat = 0;
    irq_mask = 0;
    sel = '{0, 0};
    lim = '{12288, 12288};
    foreach (cnt[k]) cnt[k] = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(a(CFG_A_IDX), 32'h0000_3000);
    rd_chk(a(CFG_B_IDX), 32'h0000_3000);
    read_status();
    wr(32'h0000_0400, 32'hffff_ffff);
    rd_chk(32'h0000_0400, 32'h0);
    for (int s = 0; s < 2; s++)
      for (int sv = 0; sv < 4; sv++)
      begin
        lv = $random(seed) & 32'h1fff;
        ch = $random(seed) & 32'h3;
        m  = $random(seed) & 32'h3;
        irq_mask = m;
        wr(a(IRQ_MASK_IDX), 32'(m));
        write_cfg(s, sv, lv);
        rd_chk(s ? a(CFG_B_IDX) : a(CFG_A_IDX), {16'h0, 2'(sv), 14'(lv)});
        adc(s, ch, 1, lv);
        adc(s, ch, 0, 16383);
        adc(1 - s, ch, 1, 16383);
        for (int i = 0; i < targ[sv] - 1 && i < 20; i++) adc(s, ch, 1, hitv(s));
        adc_idle();
        rd_chk(a(IRQ_STAT_IDX), 32'(irq_stat));
        adc(s, ch, 1, hitv(s));
        adc_idle();
        read_status();
        check_irq((irq_stat & irq_mask) != 0);
        read_status();
        adc(s, ch, 1, hitv(s));
        adc_idle();
        read_status();
        irq_stat = 0;
        wr(a(IRQ_STAT_IDX), 32'h3);
        rd_chk(a(IRQ_STAT_IDX), 32'h0);
        check_irq(1'b0);
      end
    // a changed setting drops hits counted so far
    write_cfg(0, 2, 100);
    for (int i = 0; i < 3; i++) adc(0, 1, 1, 200);
    adc_idle();
    write_cfg(0, 3, 100);
    write_cfg(0, 2, 100);
    adc(0, 1, 1, 200);
    adc_idle();
    read_status();
    // one exceedance in the first channel of either slot sets its flag
    write_cfg(0, 1, 100);
    write_cfg(1, 1, 100);
    adc(0, 0, 1, 200);
    adc(1, 0, 1, 200);
    adc_idle();
    read_status();
    // a hit standing in the address phase of a status read survives the clear
    adc_result <= {1'b1, 1'b1, 1'b0, 2'h2, 14'h3fff};
    read_status();
    adc_idle();
    flags = 32'h4;  // slot a channel 3 hit with setting 1
    read_status();
    final_report();
  end

endmodule // test_float_mode_background_monitor
